/* core/uatc_consts.vh */
// register map, field positions and reset values of the usb afe test control bank
`ifndef UATC_CONSTS_VH
`define UATC_CONSTS_VH

// bus geometry
`define UATC_ADDR_W            8
`define UATC_DATA_W            32
`define UATC_WORD_ZERO         32'h00000000

// register byte offsets
`define UATC_OFF_LINE_TEST     8'hC4
`define UATC_OFF_UPSTREAM_CTRL 8'hC8
`define UATC_OFF_IRQ_STATUS    8'hD0
`define UATC_OFF_IRQ_CLEAR     8'hD4
`define UATC_OFF_IRQ_ENABLE    8'hD8

// afe_line_test fields
`define UATC_TST_BOOST_HI      10
`define UATC_TST_BOOST_LO      8
`define UATC_TST_PULLUP_BIT    6
`define UATC_TST_PD_PLUS_BIT   5
`define UATC_TST_PD_MINUS_BIT  4
`define UATC_TST_HS_ACT_BIT    1

// afe_upstream_control fields
`define UATC_CTL_HS_TERM_BIT   29
`define UATC_CTL_SQUELCH_BIT   28
`define UATC_CTL_DISC_BIT      27
`define UATC_CTL_SQTUNE_HI     26
`define UATC_CTL_SQTUNE_LO     24

// three-bit analog trims and their fallback value
`define UATC_TRIM_W            3
`define UATC_TRIM_ZERO         3'h0
`define UATC_BIT_ZERO          1'h0

// interrupt status layout
`define UATC_IRQ_W             3
`define UATC_IRQ_ZERO          3'h0
`define UATC_IRQ_DISC_BIT      0
`define UATC_IRQ_SQUELCH_BIT   1
`define UATC_IRQ_RESTORE_BIT   2

// width of the analog status synchroniser
`define UATC_SYNC_W            2

`endif

/* core/uatc_regs.v */
// usb 2.0 afe line test and upstream control registers with interrupt logic
//
// Design decision made here: strobed register access.
`default_nettype none
`include "uatc_consts.vh"

module uatc_regs (
  // clock and reset
  input  wire                      clk_i,
  input  wire                      rst_i,
  // register port
  input  wire [`UATC_ADDR_W-1:0]   addr_i,
  input  wire [`UATC_DATA_W-1:0]   wdata_i,
  input  wire                      wr_i,
  input  wire                      rd_i,
  output reg  [`UATC_DATA_W-1:0]   rdata_o,
  // configuration image loader
  input  wire                      cfg_load_i,
  input  wire                      cfg_eeprom_present_i,
  input  wire                      cfg_otp_present_i,
  input  wire [`UATC_TRIM_W-1:0]   cfg_drive_boost_i,
  input  wire [`UATC_TRIM_W-1:0]   cfg_squelch_threshold_i,
  input  wire [`UATC_TRIM_W-1:0]   otp_drive_boost_i,
  input  wire [`UATC_TRIM_W-1:0]   otp_squelch_threshold_i,
  // soft resets from the usb core
  input  wire                      usb_reset_i,
  input  wire                      lite_soft_reset_i,
  input  wire                      rst_protect_i,
  // analog front end status and eop timing
  input  wire                      afe_hs_squelch_n_i,
  input  wire                      afe_hs_disconnect_i,
  input  wire                      hs_eop_bit32_i,
  // analog front end controls
  output reg                       pullup_term_en_o,
  output reg                       plus_line_pulldown_en_o,
  output reg                       minus_line_pulldown_en_o,
  output reg                       hs_driver_active_o,
  output reg                       hs_termination_en_o,
  output reg  [`UATC_TRIM_W-1:0]   hs_current_boost_o,
  output reg  [`UATC_TRIM_W-1:0]   squelch_trip_adjust_o,
  // interrupt
  output wire                      irq_o
);

  // synchronised analog status
  wire [`UATC_SYNC_W-1:0]  afe_sync;
  wire                     hs_squelch_n;
  wire                     disc_live;

  // last loaded image values used by soft resets
  reg  [`UATC_TRIM_W-1:0]  boost_restore;
  reg  [`UATC_TRIM_W-1:0]  squelch_restore;

  // captured disconnect flag and squelch history
  reg                      hs_disconnect_flag;
  reg                      squelch_prev;

  // interrupt registers
  reg  [`UATC_IRQ_W-1:0]   irq_status;
  reg  [`UATC_IRQ_W-1:0]   irq_enable;
  reg  [`UATC_IRQ_W-1:0]   irq_events;
  reg  [`UATC_IRQ_W-1:0]   irq_clear;
  reg  [`UATC_IRQ_W-1:0]   next_irq_status;

  // load-time defaults
  reg  [`UATC_TRIM_W-1:0]  boost_default;
  reg  [`UATC_TRIM_W-1:0]  squelch_default;
  reg  [`UATC_TRIM_W-1:0]  next_boost_restore;
  reg  [`UATC_TRIM_W-1:0]  next_squelch_restore;

  // decoded accesses
  wire                     wr_line_test;
  wire                     wr_upstream;
  wire                     wr_irq_clear;
  wire                     wr_irq_enable;
  wire                     soft_restore;
  reg  [`UATC_DATA_W-1:0]  rd_word;

  // squelch and disconnect come from the analog macro, so they are retimed first
  uatc_sync2 #(
    .W (`UATC_SYNC_W)
  ) u_afe_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({afe_hs_squelch_n_i, afe_hs_disconnect_i}),
    .q_o   (afe_sync)
  );

  assign hs_squelch_n = afe_sync[1];
  assign disc_live    = afe_sync[0];

  // address decode; reserved offsets and the status register take no write
  // write strobes for the four writable registers, plus the soft restore
  assign wr_line_test  = wr_i && (addr_i == `UATC_OFF_LINE_TEST);
  assign wr_upstream   = wr_i && (addr_i == `UATC_OFF_UPSTREAM_CTRL);
  assign wr_irq_clear  = wr_i && (addr_i == `UATC_OFF_IRQ_CLEAR);
  assign wr_irq_enable = wr_i && (addr_i == `UATC_OFF_IRQ_ENABLE);
  assign soft_restore  = usb_reset_i || lite_soft_reset_i;

  // default and restore values computed from the image being loaded
  always @* begin
    if (cfg_eeprom_present_i) begin
      boost_default = cfg_drive_boost_i;
    end else if (cfg_otp_present_i) begin
      boost_default = otp_drive_boost_i;
    end else begin
      boost_default = `UATC_TRIM_ZERO;
    end
    if (cfg_eeprom_present_i) begin
      next_boost_restore = cfg_drive_boost_i;
    end else begin
      next_boost_restore = `UATC_TRIM_ZERO;
    end
    if (cfg_eeprom_present_i) begin
      squelch_default = cfg_squelch_threshold_i;
    end else if (cfg_otp_present_i) begin
      squelch_default = otp_squelch_threshold_i;
    end else begin
      squelch_default = `UATC_TRIM_ZERO;
    end
    next_squelch_restore = squelch_default;
  end

  // remember the last loaded image (boost from eeprom only, else zero) so a soft reset can fall back to it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boost_restore   <= `UATC_TRIM_ZERO;
      squelch_restore <= `UATC_TRIM_ZERO;
    end else if (cfg_load_i) begin
      boost_restore   <= next_boost_restore;
      squelch_restore <= next_squelch_restore;
    end
  end

  // plain control bits, only the hard reset clears them
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pullup_term_en_o         <= `UATC_BIT_ZERO;
      plus_line_pulldown_en_o  <= `UATC_BIT_ZERO;
      minus_line_pulldown_en_o <= `UATC_BIT_ZERO;
      hs_driver_active_o       <= `UATC_BIT_ZERO;
      hs_termination_en_o      <= `UATC_BIT_ZERO;
    end else begin
      if (wr_line_test) begin
        pullup_term_en_o         <= wdata_i[`UATC_TST_PULLUP_BIT];
        plus_line_pulldown_en_o  <= wdata_i[`UATC_TST_PD_PLUS_BIT];
        minus_line_pulldown_en_o <= wdata_i[`UATC_TST_PD_MINUS_BIT];
        hs_driver_active_o       <= wdata_i[`UATC_TST_HS_ACT_BIT];
      end
      if (wr_upstream) begin
        hs_termination_en_o <= wdata_i[`UATC_CTL_HS_TERM_BIT];
      end
    end
  end

  // analog trims: image load beats soft restore, which beats a software write
  // so a driver write racing a bus reset cannot leave a stale trim behind
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_current_boost_o    <= `UATC_TRIM_ZERO;
      squelch_trip_adjust_o <= `UATC_TRIM_ZERO;
    end else if (cfg_load_i) begin
      hs_current_boost_o    <= boost_default;
      squelch_trip_adjust_o <= squelch_default;
    end else if (soft_restore) begin
      if (!rst_protect_i) begin
        hs_current_boost_o    <= boost_restore;
        squelch_trip_adjust_o <= squelch_restore;
      end
    end else begin
      if (wr_line_test) begin
        hs_current_boost_o <= wdata_i[`UATC_TST_BOOST_HI:`UATC_TST_BOOST_LO];
      end
      if (wr_upstream) begin
        squelch_trip_adjust_o <= wdata_i[`UATC_CTL_SQTUNE_HI:`UATC_CTL_SQTUNE_LO];
      end
    end
  end

  // disconnect is only meaningful at the 32nd eop bit time, so hold it between
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_disconnect_flag <= `UATC_BIT_ZERO;
      squelch_prev       <= `UATC_BIT_ZERO;
    end else begin
      if (hs_eop_bit32_i) begin
        hs_disconnect_flag <= disc_live;
      end
      squelch_prev <= hs_squelch_n;
    end
  end

  // interrupt events, each a one-cycle pulse
  always @* begin
    irq_events = `UATC_IRQ_ZERO;
    irq_events[`UATC_IRQ_DISC_BIT]    = hs_eop_bit32_i && disc_live;
    irq_events[`UATC_IRQ_SQUELCH_BIT] = hs_squelch_n != squelch_prev;
    irq_events[`UATC_IRQ_RESTORE_BIT] = soft_restore && !cfg_load_i;
  end

  // sticky status: a new event wins over a clear in the same cycle
  always @* begin
    irq_clear = `UATC_IRQ_ZERO;
    if (wr_irq_clear) begin
      irq_clear = wdata_i[`UATC_IRQ_W-1:0];
    end
    next_irq_status = (irq_status & ~irq_clear) | irq_events;
  end

  // status and enable registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= `UATC_IRQ_ZERO;
      irq_enable <= `UATC_IRQ_ZERO;
    end else begin
      irq_status <= next_irq_status;
      if (wr_irq_enable) begin
        irq_enable <= wdata_i[`UATC_IRQ_W-1:0];
      end
    end
  end

  // level interrupt while any enabled status bit stands
  assign irq_o = |(irq_status & irq_enable);

  // read mux; unmapped offsets and the clear register read as zero
  always @* begin
    rd_word = `UATC_WORD_ZERO;
    case (addr_i)
      `UATC_OFF_LINE_TEST: begin
        rd_word[`UATC_TST_BOOST_HI:`UATC_TST_BOOST_LO] = hs_current_boost_o;
        rd_word[`UATC_TST_PULLUP_BIT]   = pullup_term_en_o;
        rd_word[`UATC_TST_PD_PLUS_BIT]  = plus_line_pulldown_en_o;
        rd_word[`UATC_TST_PD_MINUS_BIT] = minus_line_pulldown_en_o;
        rd_word[`UATC_TST_HS_ACT_BIT]   = hs_driver_active_o;
      end
      `UATC_OFF_UPSTREAM_CTRL: begin
        rd_word[`UATC_CTL_HS_TERM_BIT] = hs_termination_en_o;
        rd_word[`UATC_CTL_SQUELCH_BIT] = hs_squelch_n;
        rd_word[`UATC_CTL_DISC_BIT]    = hs_disconnect_flag;
        rd_word[`UATC_CTL_SQTUNE_HI:`UATC_CTL_SQTUNE_LO] = squelch_trip_adjust_o;
      end
      `UATC_OFF_IRQ_STATUS: begin
        rd_word[`UATC_IRQ_W-1:0] = irq_status;
      end
      `UATC_OFF_IRQ_ENABLE: begin
        rd_word[`UATC_IRQ_W-1:0] = irq_enable;
      end
      default: begin
        rd_word = `UATC_WORD_ZERO;
      end
    endcase
  end

  // read data stand for exactly the cycle after the strobe, zero otherwise
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `UATC_WORD_ZERO;
    end else if (rd_i) begin
      rdata_o <= rd_word;
    end else begin
      rdata_o <= `UATC_WORD_ZERO;
    end
  end

endmodule

`default_nettype wire

/* core/uatc_sync2.v */
// two-flop synchroniser for levels arriving from the analog front end
`default_nettype none

module uatc_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // asynchronous levels in, synchronised levels out
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

`default_nettype wire

/* dv/uatc_afe_model.sv */
// behavioural model of the analog front end status lines
`default_nettype none
module uatc_afe_model (
  // clock and test commands
  input  wire logic clk_i,
  input  wire logic line_open_i,
  input  wire logic data_bad_i,
  input  wire logic eop_req_i,
  // status towards the register bank
  output var  logic squelch_n_o,
  output var  logic disconnect_o,
  output var  logic eop_bit32_o
);
  initial begin
    squelch_n_o = 1'b0;
    disconnect_o = 1'b0;
    eop_bit32_o = 1'b0;
  end
  // analog levels move off the clock edge, as a real comparator would
  always @(posedge clk_i) begin
    #13;
    squelch_n_o = data_bad_i;
    disconnect_o = line_open_i;
  end
  always @(posedge clk_i) eop_bit32_o <= eop_req_i;
endmodule
`default_nettype wire

/* dv/uatc_regs_sva.sv */
// assertion checker for the afe test control register bank
`default_nettype none
module uatc_regs_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register port
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // image load and soft resets
  input wire logic        cfg_load_i,
  input wire logic        cfg_eeprom_present_i,
  input wire logic        cfg_otp_present_i,
  input wire logic [2:0]  cfg_drive_boost_i,
  input wire logic [2:0]  cfg_squelch_threshold_i,
  input wire logic [2:0]  otp_drive_boost_i,
  input wire logic [2:0]  otp_squelch_threshold_i,
  input wire logic        usb_reset_i,
  input wire logic        lite_soft_reset_i,
  input wire logic        rst_protect_i,
  // afe controls
  input wire logic        pullup_term_en_o,
  input wire logic        plus_line_pulldown_en_o,
  input wire logic        minus_line_pulldown_en_o,
  input wire logic        hs_driver_active_o,
  input wire logic        hs_termination_en_o,
  input wire logic [2:0]  hs_current_boost_o,
  input wire logic [2:0]  squelch_trip_adjust_o
);
  logic [2:0] last_boost;
  logic [2:0] last_sq;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // image values a later restore must bring back; boost ignores otp on restore
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_boost <= 3'h0;
      last_sq <= 3'h0;
    end else if (cfg_load_i) begin
      last_boost <= cfg_eeprom_present_i ? cfg_drive_boost_i : 3'h0;
      last_sq <= cfg_eeprom_present_i ? cfg_squelch_threshold_i :
                 cfg_otp_present_i ? otp_squelch_threshold_i : 3'h0;
    end
  end
  sequence s_soft;
    (usb_reset_i || lite_soft_reset_i) && !cfg_load_i;
  endsequence
  sequence s_c4_wr;
    wr_i && addr_i == 8'hC4;
  endsequence
  rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  line_ctl_a: assert property (s_c4_wr |=> {pullup_term_en_o, plus_line_pulldown_en_o,
    minus_line_pulldown_en_o, hs_driver_active_o} == $past({wdata_i[6], wdata_i[5],
    wdata_i[4], wdata_i[1]})) else $error("line test controls differ from write");
  hs_term_a: assert property (wr_i && addr_i == 8'hC8 |=>
    hs_termination_en_o == $past(wdata_i[29])) else $error("hs termination wrong");
  boost_load_a: assert property (cfg_load_i |=> hs_current_boost_o == $past(
    cfg_eeprom_present_i ? cfg_drive_boost_i : cfg_otp_present_i ? otp_drive_boost_i : 3'h0))
    else $error("boost load wrong");
  squelch_load_a: assert property (cfg_load_i |=> squelch_trip_adjust_o == last_sq)
    else $error("squelch load wrong");
  restore_image_a: assert property (s_soft ##0 !rst_protect_i |=>
    hs_current_boost_o == last_boost && squelch_trip_adjust_o == last_sq)
    else $error("restore value wrong");
  restore_hold_a: assert property (s_soft ##0 rst_protect_i |=>
    $stable(hs_current_boost_o) && $stable(squelch_trip_adjust_o)) else $error("trim moved");
  c4_reserved_a: assert property (rd_i && addr_i == 8'hC4 |=>
    (rdata_o & 32'hFFFFF88D) == 32'h0) else $error("line test reserved bits set");
  c8_reserved_a: assert property (rd_i && addr_i == 8'hC8 |=>
    (rdata_o & 32'hC0FFFFFF) == 32'h0) else $error("upstream reserved bits set");
  trim_read_a: assert property (rd_i && addr_i == 8'hC8 |=>
    rdata_o[26:24] == $past(squelch_trip_adjust_o)) else $error("squelch readback wrong");
endmodule
bind uatc_regs uatc_regs_sva uatc_regs_sva_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cfg_load_i(cfg_load_i),
  .cfg_eeprom_present_i(cfg_eeprom_present_i), .cfg_otp_present_i(cfg_otp_present_i),
  .cfg_drive_boost_i(cfg_drive_boost_i), .cfg_squelch_threshold_i(cfg_squelch_threshold_i),
  .otp_drive_boost_i(otp_drive_boost_i), .otp_squelch_threshold_i(otp_squelch_threshold_i),
  .usb_reset_i(usb_reset_i), .lite_soft_reset_i(lite_soft_reset_i),
  .rst_protect_i(rst_protect_i), .pullup_term_en_o(pullup_term_en_o),
  .plus_line_pulldown_en_o(plus_line_pulldown_en_o), .hs_driver_active_o(hs_driver_active_o),
  .minus_line_pulldown_en_o(minus_line_pulldown_en_o), .hs_current_boost_o(hs_current_boost_o),
  .hs_termination_en_o(hs_termination_en_o), .squelch_trip_adjust_o(squelch_trip_adjust_o));
`default_nettype wire

/* dv/uatc_regs_tb.sv */
// self-checking bench for the afe test control register bank
`default_nettype none
module uatc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, load = 1'b0, ee = 1'b0;
  logic        otp = 1'b0, usb_rst = 1'b0, lite_rst = 1'b0, prot = 1'b0, open = 1'b0;
  logic        bad = 1'b0, eop = 1'b0, sq_n, disc, eop32, pu, pdp, pdm, hsa, term, irq;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata;
  logic [2:0]  cb = 3'h0, cs = 3'h0, ob = 3'h0, os = 3'h0, boost, sq;
  int          n_mismatch = 0, checks_done = 0;
  always #25 clk_i = ~clk_i;
  uatc_regs uatc_regs_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .cfg_load_i(load), .cfg_eeprom_present_i(ee),
    .cfg_otp_present_i(otp), .cfg_drive_boost_i(cb), .cfg_squelch_threshold_i(cs),
    .otp_drive_boost_i(ob), .otp_squelch_threshold_i(os), .usb_reset_i(usb_rst),
    .lite_soft_reset_i(lite_rst), .rst_protect_i(prot), .afe_hs_squelch_n_i(sq_n),
    .afe_hs_disconnect_i(disc), .hs_eop_bit32_i(eop32), .pullup_term_en_o(pu),
    .plus_line_pulldown_en_o(pdp), .minus_line_pulldown_en_o(pdm), .hs_driver_active_o(hsa),
    .hs_termination_en_o(term), .hs_current_boost_o(boost), .squelch_trip_adjust_o(sq),
    .irq_o(irq));
  uatc_afe_model uatc_afe_model_i (.clk_i(clk_i), .line_open_i(open), .data_bad_i(bad),
    .eop_req_i(eop), .squelch_n_o(sq_n), .disconnect_o(disc), .eop_bit32_o(eop32));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one write cycle; returns once the effect has settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(negedge clk_i);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata, e);
  endtask
  task automatic pulse(input logic l, input logic u, input logic t);
    @(posedge clk_i);
    load <= l;
    usb_rst <= u;
    lite_rst <= t;
    @(posedge clk_i);
    {load, usb_rst, lite_rst} <= 3'h0;
    @(negedge clk_i);
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'hC4, 32'h00000000);
    rd(8'hC8, 32'h00000000);
    // eeprom image wins over otp
    @(posedge clk_i) {ee, otp, cb, cs, ob, os} <= 14'h3B9C;
    pulse(1'b1, 1'b0, 1'b0);
    rd(8'hC4, 32'h00000500);
    rd(8'hC8, 32'h06000000);
    wr(8'hC4, 32'hFFFFFFFF);
    chk(32'({pu, pdp, pdm, hsa}), 32'h0000000F);
    rd(8'hC4, 32'h00000772);
    // mixed pattern so a swapped control bit cannot hide behind all ones
    wr(8'hC4, 32'h00000052);
    chk(32'({pu, pdp, pdm, hsa}), 32'h0000000B);
    wr(8'hC4, 32'h00000000);
    chk(32'({pu, pdp, pdm, hsa}), 32'h00000000);
    wr(8'hC8, 32'hFFFFFFFF);
    chk(32'(term), 32'h00000001);
    rd(8'hC8, 32'h27000000);
    for (int i = 0; i < 8; i++) begin
      wr(8'hC8, 32'(i) << 24);
      chk(32'(sq), 32'(i));
    end
    pulse(1'b0, 1'b1, 1'b0);
    chk(32'({boost, sq}), 32'h0000002E);
    wr(8'hC4, 32'h00000200);
    wr(8'hC8, 32'h01000000);
    pulse(1'b0, 1'b0, 1'b1);
    chk(32'({boost, sq}), 32'h0000002E);
    wr(8'hC4, 32'h00000200);
    @(posedge clk_i) prot <= 1'b1;
    pulse(1'b0, 1'b1, 1'b1);
    chk(32'({boost, sq}), 32'h00000016);
    // otp only: boost restore falls back to zero, squelch keeps otp
    @(posedge clk_i) {prot, ee} <= 2'h0;
    pulse(1'b1, 1'b0, 1'b0);
    chk(32'({boost, sq}), 32'h0000001C);
    pulse(1'b0, 1'b1, 1'b0);
    chk(32'({boost, sq}), 32'h00000004);
    @(posedge clk_i) otp <= 1'b0;
    pulse(1'b1, 1'b0, 1'b0);
    chk(32'({boost, sq}), 32'h00000000);
    @(posedge clk_i) {bad, open} <= 2'h3;
    repeat (4) @(posedge clk_i);
    rd(8'hC8, 32'h10000000);
    pulse(1'b0, 1'b0, 1'b0);
    @(posedge clk_i) eop <= 1'b1;
    @(posedge clk_i) {eop, open} <= 2'h0;
    repeat (4) @(posedge clk_i);
    rd(8'hC8, 32'h18000000);
    @(posedge clk_i) {eop, bad} <= 2'h2;
    @(posedge clk_i) eop <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'hC8, 32'h00000000);
    // sticky status, masked level, clear by writing ones
    rd(8'hD0, 32'h00000007);
    chk(32'(irq), 32'h00000000);
    wr(8'hD8, 32'h00000002);
    @(negedge clk_i) chk(32'(irq), 32'h00000001);
    wr(8'hD4, 32'h00000002);
    wr(8'hD0, 32'h00000000);
    @(negedge clk_i) chk(32'(irq), 32'h00000000);
    rd(8'hD0, 32'h00000005);
    rd(8'hD8, 32'h00000002);
    rd(8'h10, 32'h00000000);
    report_and_stop();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
